// File: hw/key_sampler.sv
// Samples the run and lap keys on the key sample tick and blocks
// presses that coincide with a held mask key.
// Assumes key inputs are synchronous to core_clk and high when pressed.
`timescale 1ns/1ns
`default_nettype none
module key_sampler #(
	parameter int NUM_KEYS = stopwatch_pkg::NUM_KEYS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic sampleTick,
	input wire logic roleSwap,
	input wire logic [2:0] maskSel,
	input wire logic [NUM_KEYS-1:0] keyPressed,
	// Filtered key edges
	output logic runPulse,
	output logic lapPulse
);
	logic [NUM_KEYS-1:0] prevKeys_q, prevKeys_d;
	logic runSig_q, runSig_d, lapSig_q, lapSig_d;
	logic blocked_q, blocked_d;
	logic runPulse_q, runPulse_d, lapPulse_q, lapPulse_d;
	logic runKey, lapKey, prevRun, prevLap, maskPrev, newPress;
	logic [NUM_KEYS-1:0] maskKeys;

	// Role assignment, mask lookup and block decision
	always_comb begin
		maskKeys = stopwatch_pkg::KEY_MASK_TABLE[maskSel];
		runKey = roleSwap ? keyPressed[1] : keyPressed[0];
		lapKey = roleSwap ? keyPressed[0] : keyPressed[1];
		prevRun = roleSwap ? prevKeys_q[1] : prevKeys_q[0];
		prevLap = roleSwap ? prevKeys_q[0] : prevKeys_q[1];
		maskPrev = |(prevKeys_q & maskKeys);
		newPress = (runKey && !prevRun) || (lapKey && !prevLap);
		prevKeys_d = prevKeys_q;
		blocked_d = blocked_q;
		runSig_d = runSig_q;
		lapSig_d = lapSig_q;
		runPulse_d = 1'b0;
		lapPulse_d = 1'b0;
		if (sampleTick) begin
			prevKeys_d = keyPressed;
			// block until released
			// A mask already held before the press blocks it; a mask
			// pressed in the same sample does not.
			if (!runKey && !lapKey) begin
				blocked_d = 1'b0;
			end else if (newPress && maskPrev) begin
				blocked_d = 1'b1;
			end
			runSig_d = runKey && !blocked_d;
			lapSig_d = lapKey && !blocked_d;
			runPulse_d = runSig_d && !runSig_q;
			lapPulse_d = lapSig_d && !lapSig_q;
		end
	end

	// Sampled key state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prevKeys_q <= '0;
			blocked_q <= 1'b0;
			runSig_q <= 1'b0;
			lapSig_q <= 1'b0;
			runPulse_q <= 1'b0;
			lapPulse_q <= 1'b0;
		end else begin
			prevKeys_q <= prevKeys_d;
			blocked_q <= blocked_d;
			runSig_q <= runSig_d;
			lapSig_q <= lapSig_d;
			runPulse_q <= runPulse_d;
			lapPulse_q <= lapPulse_d;
		end
	end

	assign runPulse = runPulse_q;
	assign lapPulse = lapPulse_q;

	// Blocked presses never reach the internal signals
	property p_blockedQuiet;
		@(posedge core_clk) disable iff (rst)
		blocked_q |-> !runSig_q && !lapSig_q;
	endproperty
	a_blockedQuiet: assert property (p_blockedQuiet)
		else $error("key passed while blocked");

endmodule : key_sampler
`default_nettype wire

// File: hw/stopwatch_capture_direct_input.sv
// BCD stopwatch with capture buffer, key control and event flags.
// Assumes a 125 MHz core_clk, synchronous key inputs and a register port
// whose read data appear the cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module stopwatch_capture_direct_input #(
	parameter int SAMPLE_PERIOD_CYC = stopwatch_pkg::SAMPLE_PERIOD_CYC,
	parameter int COUNT_PERIOD_CYC = stopwatch_pkg::COUNT_PERIOD_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [15:0] regAddr,
	input wire logic [3:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [3:0] regRdData,
	// Key ports, high while pressed
	input wire logic [stopwatch_pkg::NUM_KEYS-1:0] keyPressed,
	// Interrupt requests
	output logic keyRunIrq,
	output logic keyLapIrq,
	output logic oneHzIrq,
	output logic tenHzIrq
);
	localparam int SW = $clog2(SAMPLE_PERIOD_CYC);
	localparam int CW = $clog2(COUNT_PERIOD_CYC);

	// Prescalers
	logic [SW-1:0] sampleCnt_q, sampleCnt_d;
	logic [CW-1:0] countCnt_q, countCnt_d;
	logic sampleTick, countTick;

	// Control and status
	logic keySwap_q, keySwap_d;
	logic keyCtrlEn_q, keyCtrlEn_d;
	logic keyCtrlEff_q, keyCtrlEff_d;
	logic [2:0] maskSel_q, maskSel_d;
	logic running_q, running_d;
	logic [3:0] irqEn_q, irqEn_d;
	logic [3:0] irqFlag_q, irqFlag_d;
	logic [3:0] rdData_q, rdData_d;

	// Counter and capture
	logic [2:0][3:0] cnt_q, cnt_d;
	logic [2:0][3:0] cap_q, cap_d;
	logic hold_q, hold_d;
	logic lapUnread_q, lapUnread_d;
	logic renewed_q, renewed_d;
	logic lapCarry_q, lapCarry_d;

	// Decoded accesses and events
	logic runPulse, lapPulse, runEvt, lapEvt, carry;
	logic wrSwap, wrKeyCtrl, wrCtrl, wrIrqEn, wrIrqFlag, clearWr;
	logic rdThou, rdTenths;
	logic [2:0] wrap;
	logic [3:0] setEvt, clrMask;

	// Key sampling runs on the same tick that commits the enable
	key_sampler #(
		.NUM_KEYS(stopwatch_pkg::NUM_KEYS)
	) keys (
		.core_clk(core_clk),
		.rst(rst),
		.sampleTick(sampleTick),
		.roleSwap(keySwap_q),
		.maskSel(maskSel_q),
		.keyPressed(keyPressed),
		.runPulse(runPulse),
		.lapPulse(lapPulse)
	);

	// Strobe decode
	always_comb begin
		wrSwap = regWrEn && (regAddr == stopwatch_pkg::ADDR_KEY_SWAP);
		wrKeyCtrl = regWrEn && (regAddr == stopwatch_pkg::ADDR_KEY_CTRL);
		wrCtrl = regWrEn && (regAddr == stopwatch_pkg::ADDR_CTRL_STAT);
		wrIrqEn = regWrEn && (regAddr == stopwatch_pkg::ADDR_IRQ_EN);
		wrIrqFlag = regWrEn && (regAddr == stopwatch_pkg::ADDR_IRQ_FLAG);
		rdThou = regRdEn && (regAddr == stopwatch_pkg::ADDR_DIG_THOU);
		rdTenths = regRdEn && (regAddr == stopwatch_pkg::ADDR_DIG_TENTHS);
		clearWr = wrCtrl && regWrData[stopwatch_pkg::BIT_CLEAR];
		runEvt = runPulse && keyCtrlEff_q;
		lapEvt = lapPulse && keyCtrlEff_q;
	end

	// Prescalers: key sample tick runs free, count tick only while running
	always_comb begin
		sampleTick = (sampleCnt_q == SW'(SAMPLE_PERIOD_CYC - 1));
		countTick = running_q && (countCnt_q == CW'(COUNT_PERIOD_CYC - 1));
		sampleCnt_d = sampleTick ? '0 : sampleCnt_q + 1'b1;
		if (clearWr || !running_q) begin
			// Clearing restarts the millisecond phase so a running
			// clear counts a full first millisecond
			countCnt_d = clearWr ? '0 : countCnt_q;
		end else begin
			countCnt_d = countTick ? '0 : countCnt_q + 1'b1;
		end
	end

	// BCD counter with ripple carry between the three digits
	always_comb begin
		cnt_d = cnt_q;
		wrap = 3'h0;
		carry = countTick;
		for (int i = 0; i < stopwatch_pkg::NUM_DIGITS; i++) begin
			if (carry) begin
				if (cnt_q[i] == stopwatch_pkg::DIGIT_MAX) begin
					cnt_d[i] = 4'h0;
					wrap[i] = 1'b1;
				end else begin
					cnt_d[i] = cnt_q[i] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		// counter clear
		// Clear wins over a tick; the run state takes the written run bit unless under key control
		if (clearWr) begin
			cnt_d = '0;
			wrap = 3'h0;
		end
	end

	// Registers, run state, flags and capture buffer
	always_comb begin
		keySwap_d = keySwap_q;
		keyCtrlEn_d = keyCtrlEn_q;
		keyCtrlEff_d = keyCtrlEff_q;
		maskSel_d = maskSel_q;
		running_d = running_q;
		irqEn_d = irqEn_q;
		cap_d = cap_q;
		hold_d = hold_q;
		lapUnread_d = lapUnread_q;
		renewed_d = renewed_q;
		lapCarry_d = lapCarry_q;
		if (wrSwap) begin
			keySwap_d = regWrData[stopwatch_pkg::BIT_KEY_SWAP];
		end
		if (wrKeyCtrl) begin
			keyCtrlEn_d = regWrData[stopwatch_pkg::BIT_KEY_CTRL_EN];
			maskSel_d = regWrData[stopwatch_pkg::MASK_SEL_LSB +:
				stopwatch_pkg::MASK_SEL_W];
		end
		if (sampleTick) begin
			keyCtrlEff_d = keyCtrlEn_q;
		end
		if (keyCtrlEff_q) begin
			if (runEvt) begin
				running_d = !running_q;
			end
		end else if (wrCtrl) begin
			running_d = regWrData[stopwatch_pkg::BIT_RUN];
		end
		if (wrIrqEn) begin
			irqEn_d = regWrData;
		end
		setEvt = 4'h0;
		setEvt[stopwatch_pkg::BIT_IRQ_TEN] = wrap[1];
		setEvt[stopwatch_pkg::BIT_IRQ_ONE] = wrap[2];
		setEvt[stopwatch_pkg::BIT_IRQ_LAP] = lapEvt;
		setEvt[stopwatch_pkg::BIT_IRQ_RUN] = runEvt;
		clrMask = wrIrqFlag ? regWrData : 4'h0;
		irqFlag_d = (irqFlag_q & ~clrMask) | setEvt;
		// free-running capture follows the counter until held
		// The read edge keeps the digit just read, so the frozen columns
		// match what software saw even when a count tick lands there
		if (!hold_q && !rdThou) begin
			cap_d = cnt_q;
		end
		if (rdThou && !hold_q) begin
			hold_d = 1'b1;
			lapCarry_d = irqFlag_q[stopwatch_pkg::BIT_IRQ_ONE];
		end
		if (rdTenths && hold_q) begin
			renewed_d = lapUnread_q;
			lapUnread_d = 1'b0;
			hold_d = lapUnread_q;
		end
		// A lap overrides reads in the same cycle: fresh data are held
		if (lapEvt) begin
			cap_d = cnt_q;
			hold_d = 1'b1;
			lapUnread_d = hold_q;
			lapCarry_d = irqFlag_q[stopwatch_pkg::BIT_IRQ_ONE];
		end
	end

	// Read data, captured the cycle after the read strobe
	always_comb begin
		rdData_d = 4'h0;
		if (!regRdEn) begin
			rdData_d = 4'h0;
		end else if (regAddr == stopwatch_pkg::ADDR_KEY_SWAP) begin
			rdData_d[stopwatch_pkg::BIT_KEY_SWAP] = keySwap_q;
		end else if (regAddr == stopwatch_pkg::ADDR_KEY_CTRL) begin
			rdData_d = {keyCtrlEn_q, maskSel_q};
		end else if (regAddr == stopwatch_pkg::ADDR_CTRL_STAT) begin
			rdData_d = {lapCarry_q, renewed_q, running_q, 1'b0};
		end else if (regAddr == stopwatch_pkg::ADDR_DIG_THOU) begin
			rdData_d = cap_q[0];
		end else if (regAddr == stopwatch_pkg::ADDR_DIG_HUND) begin
			rdData_d = cap_q[1];
		end else if (regAddr == stopwatch_pkg::ADDR_DIG_TENTHS) begin
			rdData_d = cap_q[2];
		end else if (regAddr == stopwatch_pkg::ADDR_IRQ_EN) begin
			rdData_d = irqEn_q;
		end else if (regAddr == stopwatch_pkg::ADDR_IRQ_FLAG) begin
			rdData_d = irqFlag_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sampleCnt_q <= '0;
			countCnt_q <= '0;
			keySwap_q <= 1'b0;
			keyCtrlEn_q <= 1'b0;
			keyCtrlEff_q <= 1'b0;
			maskSel_q <= 3'h0;
			running_q <= 1'b0;
			irqEn_q <= stopwatch_pkg::REG_RESET;
			irqFlag_q <= stopwatch_pkg::REG_RESET;
			rdData_q <= 4'h0;
			cnt_q <= '0;
			cap_q <= '0;
			hold_q <= 1'b0;
			lapUnread_q <= 1'b0;
			renewed_q <= 1'b0;
			lapCarry_q <= 1'b0;
		end else begin
			sampleCnt_q <= sampleCnt_d;
			countCnt_q <= countCnt_d;
			keySwap_q <= keySwap_d;
			keyCtrlEn_q <= keyCtrlEn_d;
			keyCtrlEff_q <= keyCtrlEff_d;
			maskSel_q <= maskSel_d;
			running_q <= running_d;
			irqEn_q <= irqEn_d;
			irqFlag_q <= irqFlag_d;
			rdData_q <= rdData_d;
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			hold_q <= hold_d;
			lapUnread_q <= lapUnread_d;
			renewed_q <= renewed_d;
			lapCarry_q <= lapCarry_d;
		end
	end

	assign regRdData = rdData_q;

	assign keyRunIrq = irqFlag_q[stopwatch_pkg::BIT_IRQ_RUN] &&
		irqEn_q[stopwatch_pkg::BIT_IRQ_RUN];
	assign keyLapIrq = irqFlag_q[stopwatch_pkg::BIT_IRQ_LAP] &&
		irqEn_q[stopwatch_pkg::BIT_IRQ_LAP];
	assign oneHzIrq = irqFlag_q[stopwatch_pkg::BIT_IRQ_ONE] &&
		irqEn_q[stopwatch_pkg::BIT_IRQ_ONE];
	assign tenHzIrq = irqFlag_q[stopwatch_pkg::BIT_IRQ_TEN] &&
		irqEn_q[stopwatch_pkg::BIT_IRQ_TEN];

	// Helper: cycles that the effective enable lags the written one
	logic [SW:0] lagCnt_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lagCnt_q <= '0;
		end else begin
			lagCnt_q <= (keyCtrlEff_q != keyCtrlEn_q) ? lagCnt_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_hundredthsWrap;
		countTick && cnt_q[0] == 4'h9 && cnt_q[1] == 4'h9 && !clearWr;
	endsequence
	sequence s_renewedTenthsRead;
		rdTenths && hold_q && lapUnread_q && !lapEvt;
	endsequence

	property p_holdOnRead;
		rdThou && !hold_q |=> hold_q ##1 (hold_q || $past(rdTenths));
	endproperty
	a_holdOnRead: assert property (p_holdOnRead)
		else $error("thousandths read did not hold");

	property p_frozen;
		hold_q && !lapEvt |=> $stable(cap_q);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("held capture changed");

	property p_lagBound;
		lagCnt_q <= (SW + 1)'(SAMPLE_PERIOD_CYC);
	endproperty
	a_lagBound: assert property (p_lagBound)
		else $error("enable change took longer than a sample period");

	property p_effOnTick;
		$changed(keyCtrlEff_q) |-> $past(sampleTick);
	endproperty
	a_effOnTick: assert property (p_effOnTick)
		else $error("enable committed off the sample tick");

	property p_clear;
		clearWr |=> cnt_q == '0 && countCnt_q == '0 ##1 cnt_q == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear strobe misbehaved");

	property p_flagClear;
		wrIrqFlag && !(|setEvt) |=> (irqFlag_q & $past(regWrData)) == 4'h0;
	endproperty
	a_flagClear: assert property (p_flagClear)
		else $error("write one did not clear flag");

	property p_runIgnored;
		keyCtrlEff_q && wrCtrl && !runEvt |=> $stable(running_q);
	endproperty
	a_runIgnored: assert property (p_runIgnored)
		else $error("run write acted under key control");

	property p_tenHzEvent;
		s_hundredthsWrap |=> irqFlag_q[stopwatch_pkg::BIT_IRQ_TEN] &&
			cnt_q[1] == 4'h0;
	endproperty
	a_tenHzEvent: assert property (p_tenHzEvent)
		else $error("hundredths wrap missed ten-hz event");

	property p_renewed;
		s_renewedTenthsRead |=> renewed_q && hold_q;
	endproperty
	a_renewed: assert property (p_renewed)
		else $error("renewed capture not flagged or released");

	property p_carry;
		rdThou && !hold_q && !lapEvt |=>
			lapCarry_q == $past(irqFlag_q[stopwatch_pkg::BIT_IRQ_ONE]);
	endproperty
	a_carry: assert property (p_carry)
		else $error("lap carry not taken at hold");

endmodule : stopwatch_capture_direct_input
`default_nettype wire

// File: shared/stopwatch_pkg.sv
// Constants for the stopwatch capture block: register map, fields, timing.
// Assumes a 125 MHz core clock and a simple strobe-based register port.
// Function
// - Thousandths read freezes all capture digits
// - Three BCD capture digits at consecutive addresses
// - Capture digits are read-only
// - Capture digits reset to zero
// - Key control enable selects key or software
// - Enable change applies at next sample tick
// - Key control fields read back, reset zero
// - Swap bit exchanges run and lap keys
// - Mask code selects simultaneous-press keys
// - Masked simultaneous press ignores run and lap
// - Clear strobe resets counter, reads zero
// - Four interrupt enables, reset to zero
// - Four event flags, reset to zero
// - Write one clears flag; events always set
// - Run bit writes ignored under key control
// - Lap carry follows one-hz flag at hold
// - Renewed capture sets flag at tenths read
package stopwatch_pkg;

	// Register addresses
	localparam logic [15:0] ADDR_KEY_SWAP = 16'hFF06;
	localparam logic [15:0] ADDR_KEY_CTRL = 16'hFF78;
	localparam logic [15:0] ADDR_CTRL_STAT = 16'hFF79;
	localparam logic [15:0] ADDR_DIG_THOU = 16'hFF7A;
	localparam logic [15:0] ADDR_DIG_HUND = 16'hFF7B;
	localparam logic [15:0] ADDR_DIG_TENTHS = 16'hFF7C;
	localparam logic [15:0] ADDR_IRQ_EN = 16'hFFE6;
	localparam logic [15:0] ADDR_IRQ_FLAG = 16'hFFF6;

	// Field positions
	localparam int BIT_KEY_SWAP = 2;
	localparam int BIT_KEY_CTRL_EN = 3;
	localparam int MASK_SEL_LSB = 0;
	localparam int MASK_SEL_W = 3;
	localparam int BIT_CLEAR = 0;
	localparam int BIT_RUN = 1;
	localparam int BIT_RENEWED = 2;
	localparam int BIT_LAP_CARRY = 3;
	localparam int BIT_IRQ_TEN = 0;
	localparam int BIT_IRQ_ONE = 1;
	localparam int BIT_IRQ_LAP = 2;
	localparam int BIT_IRQ_RUN = 3;

	// Reset values and digit limits
	localparam logic [3:0] REG_RESET = 4'h0;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam int NUM_DIGITS = 3;
	localparam int NUM_KEYS = 8;

	// Mask code to key set; bit n of the key vector, K00..K03 then K10..K13
	localparam logic [7:0][7:0] KEY_MASK_TABLE = {8'hF0, 8'h70, 8'h30,
		8'h10, 8'h1C, 8'h0C, 8'h04, 8'h00};

	// Timing
	localparam int CLK_HZ = 125000000;
	localparam int KEY_SAMPLE_HZ = 1024;
	localparam int COUNT_HZ = 1000;
	localparam int KEY_SWITCH_MAX_US = 977;
	localparam int SAMPLE_PERIOD_CYC = CLK_HZ / KEY_SAMPLE_HZ;
	localparam int COUNT_PERIOD_CYC = CLK_HZ / COUNT_HZ;

endpackage : stopwatch_pkg

// File: tb/key_switch_model.sv
// Key switch bank standing in front of the block's key ports.
// Assumes the bench says which keys are held; contacts follow core_clk.
`timescale 1ns/1ns
`default_nettype none
module key_switch_model (
	// Clock
	input wire logic core_clk,
	// Keys the bench holds down
	input wire logic [7:0] holdKeys,
	// Port levels, high while pressed
	output logic [7:0] keyPressed = 8'h00
);
	// Contacts move just after an edge, never on the sampling instant
	always @(posedge core_clk) begin
		keyPressed <= holdKeys;
	end
endmodule : key_switch_model
`default_nettype wire

// File: tb/stopwatch_capture_direct_input_tb.sv
// Register-level bench for the stopwatch capture block with key control.
// Assumes short count parameters and a key switch model on the key ports.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		testsRun++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module stopwatch_capture_direct_input_tb;
	localparam logic [15:0] A_SWAP = stopwatch_pkg::ADDR_KEY_SWAP;
	localparam logic [15:0] A_KEY = stopwatch_pkg::ADDR_KEY_CTRL;
	localparam logic [15:0] A_CTL = stopwatch_pkg::ADDR_CTRL_STAT;
	localparam logic [15:0] A_THOU = stopwatch_pkg::ADDR_DIG_THOU;
	localparam logic [15:0] A_HUND = stopwatch_pkg::ADDR_DIG_HUND;
	localparam logic [15:0] A_TENTH = stopwatch_pkg::ADDR_DIG_TENTHS;
	localparam logic [15:0] A_EN = stopwatch_pkg::ADDR_IRQ_EN;
	localparam logic [15:0] A_FLAG = stopwatch_pkg::ADDR_IRQ_FLAG;
	// One member (none for code 0) and one non-member key per mask code, K00..K13 as bits 0..7
	localparam logic [7:0] IN_KEY [8] = '{8'h00, 8'h04, 8'h08, 8'h10,
		8'h10, 8'h20, 8'h40, 8'h80};
	localparam logic [7:0] OUT_KEY [8] = '{8'h04, 8'h08, 8'h10, 8'h20,
		8'h04, 8'h40, 8'h80, 8'h04};
	// Last entry is unmapped and must read zero
	localparam logic [15:0] ALL_ADDR [9] = '{A_SWAP, A_KEY, A_CTL, A_THOU,
		A_HUND, A_TENTH, A_EN, A_FLAG, 16'hFF00};

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] regAddr = 16'h0000;
	logic [3:0] regWrData = 4'h0;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [3:0] regRdData;
	logic [7:0] tapKeys = 8'h00;
	logic [7:0] maskKeys = 8'h00;
	wire [7:0] holdKeys;
	wire [7:0] keyPressed;
	logic keyRunIrq;
	logic keyLapIrq;
	logic oneHzIrq;
	logic tenHzIrq;
	logic [3:0] t0;
	logic [3:0] h0;
	logic [3:0] rdv;
	logic runExp;
	int mismatches = 0;
	int testsRun = 0;

	// Short periods keep the one-second rollover within a few thousand cycles
	stopwatch_capture_direct_input #(
		.SAMPLE_PERIOD_CYC(16),
		.COUNT_PERIOD_CYC(8)
	) i_dut (
		.core_clk(core_clk),
		.rst(rst),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.keyPressed(keyPressed),
		.keyRunIrq(keyRunIrq),
		.keyLapIrq(keyLapIrq),
		.oneHzIrq(oneHzIrq),
		.tenHzIrq(tenHzIrq)
	);

	key_switch_model i_keys (
		.core_clk(core_clk),
		.holdKeys(holdKeys),
		.keyPressed(keyPressed)
	);

	assign holdKeys = tapKeys | maskKeys;

	// 125 MHz core clock
	always #4 core_clk = ~core_clk;

	task automatic endOfTest;
		if (mismatches == 0 && testsRun > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : endOfTest

	// Idle cycle after each strobe so a strobe is never driven twice at once
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	// Data stand only in the cycle after the strobe, so sample 1 ns after the edge
	task automatic rd(input logic [15:0] a, output logic [3:0] d);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1 d = regRdData;
		@(posedge core_clk);
	endtask : rd

	task automatic ck(input logic [15:0] a, input logic [3:0] e,
		input string nm);
		logic [3:0] d;
		rd(a, d);
		`CHK(nm, e, d)
	endtask : ck

	task automatic ckBit(input logic [15:0] a, input int b, input logic e,
		input string nm);
		logic [3:0] d;
		rd(a, d);
		`CHK(nm, e, d[b])
	endtask : ckBit

	// Polls the flag register; running out of polls ends the run
	task automatic waitFlag(input int b, input int lim);
		logic [3:0] d;
		for (int i = 0; i < lim; i++) begin
			rd(A_FLAG, d);
			if (d[b] === 1'b1)
				return;
		end
		mismatches++;
		endOfTest();
	endtask : waitFlag

	// Held across two sample ticks, then released for two more
	task automatic press(input logic [7:0] k);
		tapKeys <= k;
		repeat (40) @(posedge core_clk);
		tapKeys <= 8'h00;
		repeat (40) @(posedge core_clk);
	endtask : press

	// Watchdog against a design that never answers
	initial begin
		repeat (100000) @(posedge core_clk);
		mismatches++;
		endOfTest();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (ALL_ADDR[i])
			ck(ALL_ADDR[i], 4'h0, "reset value");
		// digits ignore writes, read in order
		for (int i = 0; i < 3; i++)
			wr(A_THOU + 16'(i), 4'h5);
		for (int i = 0; i < 3; i++)
			ck(A_THOU + 16'(i), 4'h0, "digit");
		wr(A_SWAP, 4'hF);
		ck(A_SWAP, 4'h4, "swap readback");
		wr(A_KEY, 4'h7);
		ck(A_KEY, 4'h7, "key ctrl readback");
		wr(A_EN, 4'hF);
		ck(A_EN, 4'hF, "irq enable");
		wr(A_CTL, 4'h2);
		ck(A_CTL, 4'h2, "run state");
		waitFlag(stopwatch_pkg::BIT_IRQ_TEN, 1000);
		`CHK("ten hz irq", 1'b1, tenHzIrq)
		wr(A_FLAG, 4'h1);
		ck(A_FLAG, 4'h0, "flag clear");
		`CHK("ten hz irq off", 1'b0, tenHzIrq)
		waitFlag(stopwatch_pkg::BIT_IRQ_ONE, 5000);
		`CHK("one hz irq", 1'b1, oneHzIrq)
		// hold freezes digits, carry follows one-hz flag
		rd(A_THOU, t0);
		rd(A_HUND, h0);
		repeat (100) @(posedge core_clk);
		ck(A_THOU, t0, "held thousandths");
		ck(A_HUND, h0, "held hundredths");
		ck(A_CTL, 4'hA, "lap carry set");
		rd(A_TENTH, rdv);
		wr(A_FLAG, 4'hF);
		rd(A_THOU, rdv);
		ck(A_CTL, 4'h2, "lap carry clear");
		rd(A_HUND, rdv);
		rd(A_TENTH, rdv);
		wr(A_CTL, 4'h0);
		wr(A_CTL, 4'h1);
		ck(A_CTL, 4'h0, "cleared state");
		for (int i = 0; i < 3; i++)
			ck(A_THOU + 16'(i), 4'h0, "cleared digit");
		wr(A_SWAP, 4'h0);
		wr(A_KEY, 4'h8);
		repeat (40) @(posedge core_clk);
		wr(A_CTL, 4'h2);
		ck(A_CTL, 4'h0, "run write ignored");
		press(8'h01);
		ck(A_CTL, 4'h2, "key run");
		ck(A_FLAG, 4'h8, "run event");
		`CHK("run irq", 1'b1, keyRunIrq)
		// swapped key gives lap, second lap renews
		wr(A_SWAP, 4'h4);
		press(8'h01);
		ck(A_FLAG, 4'hC, "lap event");
		ck(A_CTL, 4'h2, "lap hold state");
		`CHK("lap irq", 1'b1, keyLapIrq)
		press(8'h01);
		rd(A_THOU, rdv);
		rd(A_HUND, rdv);
		rd(A_TENTH, rdv);
		ck(A_CTL, 4'h6, "renewed flag");
		// every mask code, member blocks and non-member passes
		runExp = 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(A_KEY, {1'b1, 3'(c)});
			if (c != 0) begin
				wr(A_FLAG, 4'hF);
				maskKeys <= IN_KEY[c];
				repeat (40) @(posedge core_clk);
				press(8'h02);
				maskKeys <= 8'h00;
				repeat (40) @(posedge core_clk);
				ckBit(A_CTL, 1, runExp, "masked run");
				ckBit(A_FLAG, 3, 1'b0, "masked event");
			end
			wr(A_FLAG, 4'hF);
			maskKeys <= OUT_KEY[c];
			repeat (40) @(posedge core_clk);
			press(8'h02);
			maskKeys <= 8'h00;
			repeat (40) @(posedge core_clk);
			runExp = ~runExp;
			ckBit(A_CTL, 1, runExp, "unmasked run");
			ckBit(A_FLAG, 3, 1'b1, "unmasked event");
		end
		// disabled keys leave run to software
		wr(A_KEY, 4'h0);
		repeat (40) @(posedge core_clk);
		press(8'h02);
		ckBit(A_CTL, 1, runExp, "keys ignored");
		wr(A_CTL, 4'h0);
		ckBit(A_CTL, 1, 1'b0, "software stop");
		wr(A_CTL, 4'h2);
		ckBit(A_CTL, 1, 1'b1, "software run");
		wr(A_EN, 4'h7);
		ckBit(A_FLAG, 3, 1'b1, "run flag kept");
		`CHK("run irq masked", 1'b0, keyRunIrq)
		endOfTest();
	end
endmodule : stopwatch_capture_direct_input_tb
`default_nettype wire
